// ### core/timer_defs.svh
// constants for the paired timer control block: register map, field positions, reset values.
// assumes a word-addressed avalon-mm slave with 32-bit data, registers in the low 16 bits.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// register word indices (byte address is four times the index)
`define REG_CONTROL 2'h0
`define REG_COUNT_LO 2'h1
`define REG_COUNT_HI 2'h2
`define REG_STATUS 2'h3

// control register field positions
`define CTL_RUN_BIT 15
`define CTL_IDLE_HALT_BIT 13
`define CTL_GATE_BIT 6
`define CTL_PS_HI_BIT 5
`define CTL_PS_LO_BIT 4
`define CTL_WIDE_BIT 3
`define CTL_SRC_BIT 1

// implemented bits of the control register; all others read as zero
`define CTL_WRITE_MASK 16'hA07A
`define CTL_RESET 16'h0000
`define COUNT_RESET 32'h0000_0000

// status register field positions
`define STS_ACTIVE_BIT 0
`define STS_IDLE_BIT 1
`define STS_GATE_BIT 2
`define STS_PIN_BIT 3

// prescaler terminal counts (divisor minus one)
`define PS_TERM_1 8'h00
`define PS_TERM_8 8'h07
`define PS_TERM_64 8'h3F
`define PS_TERM_256 8'hFF

`endif

// ### core/timer_pkg.sv
// types shared by the paired timer control block and its prescaler.
// assumes timer_defs.svh is on the include path.
`include "timer_defs.svh"

package timer_pkg;
	typedef logic [15:0] ctrl_word_t;
	typedef logic [1:0] ps_code_t;
	typedef logic [7:0] ps_count_t;

	// avalon handshake states
	typedef enum logic {BUS_WAIT, BUS_ACK} bus_state_e;

	// terminal count of the prescaler for a given select code
	function automatic ps_count_t ps_terminal(input ps_code_t code);
		case (code)
			2'h3: ps_terminal = `PS_TERM_256;
			2'h2: ps_terminal = `PS_TERM_64;
			2'h1: ps_terminal = `PS_TERM_8;
			default: ps_terminal = `PS_TERM_1;
		endcase
	endfunction : ps_terminal
endpackage : timer_pkg

// ### core/tick_if.sv
// carrier between the timer control and its prescaler.
// assumes both ends run on the same clock.
`timescale 1ns/100ps

interface tick_if;
	import timer_pkg::*;
	logic tick;
	logic clear;
	ps_code_t scale;
	logic inc;

	modport ctrl (output tick, output clear, output scale, input inc);
	modport pre (input tick, input clear, input scale, output inc);
endinterface : tick_if

// ### core/tick_prescaler.sv
// input clock prescaler: passes one of every 1, 8, 64 or 256 qualified ticks.
// assumes tick is a one-cycle qualified pulse from the same clock domain.
`timescale 1ns/100ps

module tick_prescaler (
	input wire logic clk_in,
	input wire logic reset_in,
	tick_if.pre bus
);
	import timer_pkg::*;

	ps_count_t count_reg;
	logic inc_reg;

	// divide the tick stream; clear restarts the division
	always_ff @(posedge clk_in) begin
		if (reset_in || bus.clear) begin
			count_reg <= 8'h00;
		end else if (bus.tick) begin
			if (count_reg >= ps_terminal(bus.scale)) begin
				count_reg <= 8'h00;
			end else begin
				count_reg <= count_reg + 8'h01;
			end
		end
	end

	// one increment pulse per completed division
	always_ff @(posedge clk_in) begin
		if (reset_in || bus.clear) begin
			inc_reg <= 1'b0;
		end else begin
			inc_reg <= bus.tick && (count_reg >= ps_terminal(bus.scale));
		end
	end

	assign bus.inc = inc_reg;
endmodule : tick_prescaler

// ### core/paired_timer_control.sv
// paired timer control: control register, tick selection, gating, idle halt and the counter.
// assumes an avalon-mm master on CLK_IN; count pin and gate come from outside and are synchronised here.
// Summary of operation
// - run bit starts, clear stops the counter
// - wide mode joins halves into 32-bit counter
// - prescale code selects 1:1, 1:8, 1:64, 1:256
// - gate bit counts only while gate active, internal clock source only
// - source bit picks pin edges or internal clock
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps

module paired_timer_control (
	input wire logic CLK_IN,
	input wire logic RESET_IN,
	input wire logic [1:0] ADDRESS_IN,
	input wire logic READ_IN,
	input wire logic WRITE_IN,
	input wire logic [31:0] WRITEDATA_IN,
	input wire logic [3:0] BYTEENABLE_IN,
	output logic [31:0] READDATA_OUT,
	output logic WAITREQUEST_OUT,
	input wire logic EXT_COUNT_PIN_IN,
	input wire logic GATE_IN,
	input wire logic IDLE_IN,
	output logic [31:0] COUNT_OUT,
	output logic RUNNING_OUT
);
	import timer_pkg::*;

	tick_if tk ();

	bus_state_e bus_state_reg;
	bus_state_e bus_state_next;
	logic waitrequest_reg;
	logic [31:0] readdata_reg;
	ctrl_word_t ctrl_reg;
	logic [31:0] count_reg;
	logic running_reg;
	logic [2:0] pin_sync_reg;
	logic [1:0] gate_sync_reg;
	logic wr_take;
	logic rd_take;
	logic run_bit;
	logic wide_bit;
	logic gate_bit;
	logic src_bit;
	logic idle_halt_bit;
	logic halted;
	logic active;
	logic pin_rise;
	logic qual_tick;
	logic ps_clear;
	ctrl_word_t ctrl_wdata;

	// merge the low 16 bits of write data under byte enables
	function automatic logic [15:0] merge16(input logic [15:0] old_val, input logic [31:0] wdata,
		input logic [3:0] be);
		logic [15:0] res;
		res = old_val;
		if (be[0]) begin
			res[7:0] = wdata[7:0];
		end
		if (be[1]) begin
			res[15:8] = wdata[15:8];
		end
		return res;
	endfunction : merge16

	// control fields
	assign run_bit = ctrl_reg[`CTL_RUN_BIT];
	assign idle_halt_bit = ctrl_reg[`CTL_IDLE_HALT_BIT];
	assign gate_bit = ctrl_reg[`CTL_GATE_BIT];
	assign wide_bit = ctrl_reg[`CTL_WIDE_BIT];
	assign src_bit = ctrl_reg[`CTL_SRC_BIT];

	// bus handshake: a write is taken in the cycle the slave drops waitrequest, a read in the wait cycle before it
	assign wr_take = WRITE_IN && (bus_state_reg == BUS_ACK);
	assign rd_take = READ_IN && (bus_state_reg == BUS_WAIT);

	// handshake state: one wait cycle, one acknowledge cycle
	always_comb begin
		bus_state_next = BUS_WAIT;
		case (bus_state_reg)
			BUS_WAIT: begin
				if (READ_IN || WRITE_IN) begin
					bus_state_next = BUS_ACK;
				end
			end
			BUS_ACK: bus_state_next = BUS_WAIT;
			default: bus_state_next = BUS_WAIT;
		endcase
	end

	// handshake state register
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			bus_state_reg <= BUS_WAIT;
		end else begin
			bus_state_reg <= bus_state_next;
		end
	end

	// waitrequest is low only in the acknowledge cycle
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			waitrequest_reg <= 1'b1;
		end else begin
			waitrequest_reg <= (bus_state_next != BUS_ACK);
		end
	end

	// read data is captured one cycle ahead so it stands during the acknowledge cycle
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			readdata_reg <= 32'h0000_0000;
		end else if (rd_take) begin
			case (ADDRESS_IN)
				`REG_CONTROL: readdata_reg <= {16'h0000, ctrl_reg & `CTL_WRITE_MASK};
				`REG_COUNT_LO: readdata_reg <= {16'h0000, count_reg[15:0]};
				`REG_COUNT_HI: readdata_reg <= {16'h0000, count_reg[31:16]};
				`REG_STATUS: readdata_reg <= {28'h0000000, pin_sync_reg[1], gate_sync_reg[1], halted, running_reg};
				default: readdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// control register; unimplemented bits stay zero
	assign ctrl_wdata = merge16(ctrl_reg, WRITEDATA_IN, BYTEENABLE_IN) & `CTL_WRITE_MASK;

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			ctrl_reg <= `CTL_RESET;
		end else if (wr_take && (ADDRESS_IN == `REG_CONTROL)) begin
			ctrl_reg <= ctrl_wdata;
		end
	end

	// two-stage synchroniser for the count pin plus one stage for edge detection
	// only the second stage feeds logic; the third just remembers the previous level
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			pin_sync_reg <= 3'h0;
		end else begin
			pin_sync_reg <= {pin_sync_reg[1:0], EXT_COUNT_PIN_IN};
		end
	end

	// two-stage synchroniser for the gate input
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			gate_sync_reg <= 2'h0;
		end else begin
			gate_sync_reg <= {gate_sync_reg[0], GATE_IN};
		end
	end

	// rising edge seen on the synchronised pin
	assign pin_rise = pin_sync_reg[1] && !pin_sync_reg[2];

	// idle comes from logic on this clock, so it is used without synchronising
	// idle handling: with the halt bit clear the timer ignores idle
	assign halted = idle_halt_bit && IDLE_IN;
	assign active = run_bit && !halted;

	// tick source: pin edges, gated peripheral clock or every peripheral clock
	always_comb begin
		if (src_bit) begin
			qual_tick = active && pin_rise; // gate ignored here
		end else if (gate_bit) begin
			qual_tick = active && gate_sync_reg[1];
		end else begin
			qual_tick = active;
		end
	end

	// prescaler restarts when stopped or when control is rewritten
	assign ps_clear = !run_bit || (wr_take && (ADDRESS_IN == `REG_CONTROL));

	assign tk.tick = qual_tick;
	assign tk.clear = ps_clear;
	assign tk.scale = ctrl_reg[`CTL_PS_HI_BIT:`CTL_PS_LO_BIT];

	tick_prescaler u_prescaler (
		.clk_in(CLK_IN),
		.reset_in(RESET_IN),
		.bus(tk.pre)
	);

	// counter: software load wins over an increment in the same cycle
	// in single mode the upper half belongs to the partner timer and holds
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			count_reg <= `COUNT_RESET;
		end else if (wr_take && (ADDRESS_IN == `REG_COUNT_LO)) begin
			count_reg[15:0] <= merge16(count_reg[15:0], WRITEDATA_IN, BYTEENABLE_IN);
		end else if (wr_take && (ADDRESS_IN == `REG_COUNT_HI)) begin
			count_reg[31:16] <= merge16(count_reg[31:16], WRITEDATA_IN, BYTEENABLE_IN);
		end else if (tk.inc && active) begin
			if (wide_bit) begin
				count_reg <= count_reg + 32'h0000_0001;
			end else begin
				count_reg[15:0] <= count_reg[15:0] + 16'h0001; // upper half untouched
			end
		end
	end

	// running status
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			running_reg <= 1'b0;
		end else begin
			running_reg <= active;
		end
	end

	assign READDATA_OUT = readdata_reg;
	assign WAITREQUEST_OUT = waitrequest_reg;
	assign COUNT_OUT = count_reg;
	assign RUNNING_OUT = running_reg;
endmodule : paired_timer_control

// ### testbench/ext_pin_driver.sv
// partner model: the external source that drives the count pin.
// assumes the bench calls pulses() from its own sequence; the pin rests low between bursts.
`timescale 1ns/100ps

module ext_pin_driver (
	input wire logic clk_in,
	output logic pin_out
);
	initial pin_out = 1'b0;
	// n rising edges, high held for half cycles and low for half plus one, at least two
	task automatic pulses(input int n, input int half);
		repeat (n) begin
			@(posedge clk_in);
			pin_out <= 1'b1;
			repeat (half) @(posedge clk_in);
			pin_out <= 1'b0;
			repeat (half) @(posedge clk_in);
		end
	endtask : pulses
endmodule : ext_pin_driver

// ### testbench/paired_timer_control_checker.sv
// checker: port assertions for the paired timer control.
// assumes the control word changes at the write acknowledge edge, masked to its implemented bits.
`timescale 1ns/100ps

module paired_timer_control_checker (
	input wire logic CLK_IN,
	input wire logic RESET_IN,
	input wire logic [1:0] ADDRESS_IN,
	input wire logic WRITE_IN,
	input wire logic [31:0] WRITEDATA_IN,
	input wire logic WAITREQUEST_OUT,
	input wire logic EXT_COUNT_PIN_IN,
	input wire logic GATE_IN,
	input wire logic IDLE_IN,
	input wire logic [31:0] COUNT_OUT,
	input wire logic RUNNING_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);
	logic [15:0] ctl_reg;
	// shadow of the control word
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			ctl_reg <= 16'h0000;
		end else if (WRITE_IN && !WAITREQUEST_OUT && ADDRESS_IN == 2'h0) begin
			ctl_reg <= WRITEDATA_IN[15:0] & 16'hA07A;
		end
	end
	a_wait_single: assert property ($fell(WAITREQUEST_OUT) |=> WAITREQUEST_OUT) else $error("long ack");
	a_stop_hold: assert property ((!RUNNING_OUT && !WRITE_IN) [*3] |=> $stable(COUNT_OUT))
		else $error("count moved while stopped");
	a_upper_hold: assert property (!ctl_reg[3] && !WRITE_IN |=> $stable(COUNT_OUT[31:16]))
		else $error("upper half moved in single mode");
	a_unit_step: assert property ((RUNNING_OUT && ctl_reg == 16'h8000 && !WRITE_IN) [*3]
		|=> COUNT_OUT[15:0] == $past(COUNT_OUT[15:0]) + 16'h0001) else $error("no 1:1 step");
	a_scale_gap: assert property (ctl_reg[5:4] != 2'h0 && !ctl_reg[1] && $changed(COUNT_OUT[15:0])
		|=> $stable(COUNT_OUT[15:0]) [*7]) else $error("prescaled step too soon");
	a_gate_hold: assert property ((ctl_reg[6] && !ctl_reg[1] && !GATE_IN) [*4] |=> $stable(COUNT_OUT))
		else $error("count moved with gate low");
	a_pin_hold: assert property ((ctl_reg[1] && !EXT_COUNT_PIN_IN) [*6] |=> $stable(COUNT_OUT))
		else $error("count moved without pin edge");
	a_idle_halt: assert property ((ctl_reg[13] && IDLE_IN) [*3] |=> $stable(COUNT_OUT) && !RUNNING_OUT)
		else $error("count moved in idle");
	c_wide: cover property (RUNNING_OUT && ctl_reg[3]);
	c_pin: cover property (ctl_reg[1] && $rose(EXT_COUNT_PIN_IN));
	c_idle: cover property (ctl_reg[13] && IDLE_IN);
endmodule : paired_timer_control_checker

bind paired_timer_control paired_timer_control_checker u_chk (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
	.ADDRESS_IN(ADDRESS_IN), .WRITE_IN(WRITE_IN), .WRITEDATA_IN(WRITEDATA_IN), .WAITREQUEST_OUT(WAITREQUEST_OUT),
	.EXT_COUNT_PIN_IN(EXT_COUNT_PIN_IN), .GATE_IN(GATE_IN), .IDLE_IN(IDLE_IN), .COUNT_OUT(COUNT_OUT),
	.RUNNING_OUT(RUNNING_OUT));

// ### testbench/paired_timer_control_bench.sv
// bench: the timer control over avalon-mm, count pin from the partner model.
// assumes count registers are loaded only while the counter is stopped.
`timescale 1ns/100ps

module paired_timer_control_bench;
	logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, gate = 1'b0, idle = 1'b0;
	logic [1:0] addr = 2'h0;
	logic [31:0] wdata = 32'h0, rdata, count, q, c;
	logic waitreq, running, pin;
	int mismatches = 0, total_checks = 0;
	int divs[4] = '{1, 8, 64, 256};
	always #10 clk = ~clk;
	ext_pin_driver u_pin (.clk_in(clk), .pin_out(pin));
	paired_timer_control u_dut (.CLK_IN(clk), .RESET_IN(rst), .ADDRESS_IN(addr), .READ_IN(rd), .WRITE_IN(wr),
		.WRITEDATA_IN(wdata), .BYTEENABLE_IN(4'hF), .READDATA_OUT(rdata), .WAITREQUEST_OUT(waitreq),
		.EXT_COUNT_PIN_IN(pin), .GATE_IN(gate), .IDLE_IN(idle), .COUNT_OUT(count), .RUNNING_OUT(running));
	task automatic summarize();
		if (mismatches == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// one access held until waitrequest is sampled low
	task automatic access(input logic w, input logic [1:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		n = 0;
		@(posedge clk);
		while (waitreq !== 1'b0 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20) begin
			check(32'h0, 32'h1);
			summarize();
		end
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : access
	task automatic settle(input int n);
		repeat (n) @(negedge clk);
		c = count;
	endtask : settle
	task automatic t_reset_map();
		access(1'b0, 2'h0, 32'h0);
		check(q, 32'h0);
		check(count, 32'h0);
		access(1'b1, 2'h0, 32'hFFFF_FFFF);
		access(1'b0, 2'h0, 32'h0);
		check(q, 32'h0000_A07A);
		access(1'b1, 2'h0, 32'h0);
	endtask : t_reset_map
	task automatic t_wrap(input logic [31:0] mode, input logic [31:0] hi);
		access(1'b1, 2'h1, 32'hFFFE);
		access(1'b1, 2'h2, 32'h0);
		access(1'b1, 2'h0, mode);
		settle(12);
		access(1'b1, 2'h0, 32'h0);
		settle(6);
		check({16'h0000, count[31:16]}, hi);
		access(1'b0, 2'h2, 32'h0);
		check(q, hi);
		repeat (20) @(negedge clk);
		check(count, c);
	endtask : t_wrap
	task automatic t_prescale();
		int n;
		for (int k = 0; k < 4; k++) begin
			access(1'b1, 2'h0, 32'h8000 | (k << 4));
			settle(1);
			q = c;
			n = 0;
			while (count === q && n < 600) begin
				settle(1);
				n++;
			end
			if (n >= 600) begin
				check(32'h0, 32'h1);
				summarize();
			end
			repeat (3 * divs[k] - 1) @(negedge clk);
			check(count, c + 32'h2);
			access(1'b1, 2'h0, 32'h0);
		end
	endtask : t_prescale
	task automatic t_gate_ext();
		access(1'b1, 2'h0, 32'h8040);
		settle(2);
		repeat (20) @(negedge clk);
		check(count, c);
		@(posedge clk);
		gate <= 1'b1;
		// two sync stages and the tick stage delay the first step to the fourth edge
		repeat (20) @(negedge clk);
		check(count, c + 32'h10);
		@(posedge clk);
		gate <= 1'b0;
		access(1'b1, 2'h0, 32'h8042);
		settle(8);
		u_pin.pulses(3, 2);
		u_pin.pulses(2, 7);
		repeat (12) @(negedge clk);
		check(count, c + 32'h5);
	endtask : t_gate_ext
	task automatic t_idle();
		@(posedge clk);
		idle <= 1'b1;
		access(1'b1, 2'h0, 32'hA000);
		settle(10);
		repeat (10) @(negedge clk);
		check(count, c);
		check({31'h0, running}, 32'h0);
		access(1'b0, 2'h3, 32'h0);
		check(q, 32'h0000_0002);
		access(1'b1, 2'h0, 32'h8000);
		// first step lands on the second edge after the acknowledge, then one per edge
		repeat (10) @(negedge clk);
		check(count, c + 32'h8);
		check({31'h0, running}, 32'h1);
		@(posedge clk);
		idle <= 1'b0;
		access(1'b1, 2'h0, 32'h0);
	endtask : t_idle
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset_map();
		t_wrap(32'h8000, 32'h0);
		t_wrap(32'h8008, 32'h1);
		t_prescale();
		t_gate_ext();
		t_idle();
		summarize();
	end
endmodule : paired_timer_control_bench
